// File: hdl/test_dump_pkg.sv
// constants and types shared by the test-mode configuration dump logic
package test_dump_pkg;

	// configuration register offsets
	localparam logic [6:0] DEVICE_ID_REG_OFFSET = 7'h00;
	localparam logic [6:0] DUMP_SELECT_REG_OFFSET = 7'h15;
	localparam logic [6:0] DUMP_SOURCE_REG_OFFSET = 7'h18;

	// field positions inside those registers
	localparam int SLAVE_ID_POS = 0;
	localparam int SLAVE_ID_WIDTH = 7;
	localparam int DUMP_SELECT_POS = 6;
	localparam int DUMP_SELECT_WIDTH = 2;
	localparam int DUMP_SOURCE_POS = 7;

	// reset values of the fields
	localparam logic [1:0] DUMP_SELECT_RESET = 2'h0;
	localparam logic DUMP_SOURCE_RESET = 1'b0;

	// dump select codes
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_PARTIAL = 2'h1;
	localparam logic [1:0] SEL_RELOAD_ONLY = 2'h2;
	localparam logic [1:0] SEL_FULL = 2'h3;

	// address ranges streamed during test mode
	localparam logic [6:0] EEPROM_FIRST_ADDR = 7'h00;
	localparam logic [6:0] EEPROM_LAST_ADDR = 7'h7F;
	localparam logic [6:0] EEPROM_OEM_FIRST_ADDR = 7'h1B;
	localparam logic [6:0] RAM_OEM_FIRST_ADDR = 7'h3B;
	localparam logic [6:0] RAM_OEM_LAST_ADDR = 7'h43;
	// last address of the shortened reload after test mode
	localparam logic [6:0] RELOAD_SHORT_LAST_ADDR = 7'h21;

	// link timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int FAST_PERIOD_NS = 780;
	localparam real SLOW_PERIOD_US = 3.125;
	localparam int DIV_WIDTH = 8;
	localparam logic [DIV_WIDTH-1:0] FAST_PERIOD_CYCLES =
		DIV_WIDTH'(FAST_PERIOD_NS / CLK_PERIOD_NS);
	localparam logic [DIV_WIDTH-1:0] SLOW_PERIOD_CYCLES =
		DIV_WIDTH'(int'($floor(SLOW_PERIOD_US * 1000.0 / CLK_PERIOD_NS)));
	// pause after each byte, in output clock periods
	localparam logic [4:0] PAUSE_PERIODS = 5'h12;
	// start bit plus data bits
	localparam logic [3:0] FRAME_BITS = 4'h9;

	// fifo shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		MODE_IDLE = 3'b001,
		MODE_SEND = 3'b010,
		MODE_HOLD = 3'b100
	} mode_state_type;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_BITS = 3'b010,
		TX_PAUSE = 3'b100
	} tx_state_type;

endpackage

// File: hdl/byte_fifo_if.sv
// carrier between the dump engine and its byte fifo
`timescale 1ns/10ps
interface byte_fifo_if #(
	parameter int WIDTH = 8
);
	logic wr_valid;
	logic wr_ready;
	logic [WIDTH-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [WIDTH-1:0] rd_data;
	logic flush;

	modport user (
		output wr_valid, wr_data, rd_ready, flush,
		input wr_ready, rd_valid, rd_data
	);

	modport store (
		input wr_valid, wr_data, rd_ready, flush,
		output wr_ready, rd_valid, rd_data
	);
endinterface

// File: hdl/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic resetn,
	byte_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} fifo_state_type;

	fifo_state_type st_reg;
	fifo_state_type st_next;
	logic full;
	logic empty;

	// depth must be a power of two for the wrap bit to work
	assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
	assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) &&
		(st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
	assign port.wr_ready = !full;
	assign port.rd_valid = !empty;
	assign port.rd_data = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

	always_comb begin
		st_next = st_reg;
		if (port.flush) begin
			st_next.wr_ptr = '0;
			st_next.rd_ptr = '0;
		end else begin
			if (port.wr_valid && !full) begin
				st_next.mem[st_reg.wr_ptr[AW-1:0]] = port.wr_data;
				st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
			end
			if (port.rd_ready && !empty) begin
				st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

// File: hdl/test_mode_config_dump.sv
// test-mode configuration dump: manchester stream on the alarm pin sink
`timescale 1ns/10ps
//
// Behaviour
// - enter test mode when pin is above entry threshold and select bit0 set
// - dump source is RAM when source select is 1 and code is not 11, else fresh EEPROM read
// - pin below exit threshold ends test mode and aborts the stream at once
// - output clock period 780 ns when fast rate set, else 3.12 us (3.125 us rounded down to 156 clocks)
// - each bit spans two clock periods; sink toggles off and 2 mA on
// - zero bit is off then on; one bit is on then off
// - byte frame: start bit one, 8 data bits, then pause with sink off
// - data bits go most significant first, right after the start bit
// - leaving with select code 00 keeps running with no reload
// - leaving with nonzero select reloads from EEPROM at the stored slave id
// - reload reads whole EEPROM for code 11, otherwise up to 0x21
// - code 01: EEPROM 0x1B-0x7F, or RAM 0x3B-0x43 when source is RAM
// - code 11 sends EEPROM 0x00-0x7F; code 10 keeps normal operation
// - RAM source is honoured only while slave operation is enabled
module test_mode_config_dump (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic test_entry_above,
	input wire logic test_exit_below,
	input wire logic [7:0] cfg_id_byte,
	input wire logic [7:0] cfg_select_byte,
	input wire logic [7:0] cfg_source_byte,
	input wire logic fast_bit_rate_select,
	input wire logic slave_operation_enable,
	output logic mem_req,
	output logic mem_from_ram,
	output logic [6:0] mem_addr,
	output logic [6:0] mem_slave_id,
	input wire logic mem_ack,
	input wire logic [7:0] mem_data,
	output logic alarm_pin_out,
	output logic alarm_pin_oe,
	output logic test_mode_active,
	output logic reload_req,
	output logic [6:0] reload_last_addr,
	output logic [6:0] reload_slave_id
);

	typedef struct packed {
		test_dump_pkg::mode_state_type mode;
		test_dump_pkg::tx_state_type tx;
		logic from_ram;
		logic fetch_busy;
		logic fetch_done;
		logic [6:0] fetch_addr;
		logic [6:0] last_addr;
		logic [6:0] slave_id;
		logic [8:0] shift;
		logic [3:0] bit_cnt;
		logic second_half;
		logic [test_dump_pkg::DIV_WIDTH-1:0] div_cnt;
		logic [4:0] pause_cnt;
		logic sink_on;
		logic reload_req;
		logic [6:0] reload_last;
		logic [6:0] reload_id;
	} state_type;

	localparam state_type STATE_RESET = '{
		mode: test_dump_pkg::MODE_IDLE,
		tx: test_dump_pkg::TX_IDLE,
		from_ram: 1'b0,
		fetch_busy: 1'b0,
		fetch_done: 1'b0,
		fetch_addr: 7'h00,
		last_addr: 7'h00,
		slave_id: 7'h00,
		shift: 9'h000,
		bit_cnt: 4'h0,
		second_half: 1'b0,
		div_cnt: '0,
		pause_cnt: 5'h00,
		sink_on: 1'b0,
		reload_req: 1'b0,
		reload_last: 7'h00,
		reload_id: 7'h00
	};

	state_type st_reg;
	state_type st_next;

	logic [1:0] sel;
	logic source_ram;
	logic ram_ok;
	logic [test_dump_pkg::DIV_WIDTH-1:0] period_cycles;
	logic tick;
	logic sending;

	byte_fifo_if #(.WIDTH(test_dump_pkg::FIFO_WIDTH)) fifo_bus ();

	byte_fifo #(
		.WIDTH(test_dump_pkg::FIFO_WIDTH),
		.DEPTH(test_dump_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.port(fifo_bus.store)
	);

	// field extraction from the configuration bytes
	assign sel = cfg_select_byte[test_dump_pkg::DUMP_SELECT_POS +:
		test_dump_pkg::DUMP_SELECT_WIDTH];
	assign source_ram = cfg_source_byte[test_dump_pkg::DUMP_SOURCE_POS];
	// ram is only readable while acting as bus slave
	assign ram_ok = source_ram && slave_operation_enable;

	// one clock period per manchester half
	assign period_cycles = fast_bit_rate_select ?
		test_dump_pkg::FAST_PERIOD_CYCLES :
		test_dump_pkg::SLOW_PERIOD_CYCLES;
	assign tick = st_reg.div_cnt == period_cycles - 1'b1;
	assign sending = st_reg.mode != test_dump_pkg::MODE_IDLE;

	always_comb begin
		st_next = st_reg;
		st_next.reload_req = 1'b0;
		fifo_bus.wr_valid = 1'b0;
		fifo_bus.wr_data = mem_data;
		fifo_bus.rd_ready = 1'b0;
		fifo_bus.flush = 1'b0;

		// divider restarts with every frame so the first half is full
		if (st_reg.tx == test_dump_pkg::TX_IDLE || tick) begin
			st_next.div_cnt = '0;
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 1'b1;
		end

		case (st_reg.mode)
			test_dump_pkg::MODE_IDLE: begin
				fifo_bus.flush = 1'b1;
				if (test_entry_above && !test_exit_below && sel[0]) begin
					st_next.mode = test_dump_pkg::MODE_SEND;
					st_next.tx = test_dump_pkg::TX_IDLE;
					st_next.fetch_busy = 1'b0;
					st_next.fetch_done = 1'b0;
					st_next.sink_on = 1'b0;
					st_next.slave_id = cfg_id_byte[
						test_dump_pkg::SLAVE_ID_POS +:
						test_dump_pkg::SLAVE_ID_WIDTH];
					if (sel == test_dump_pkg::SEL_FULL) begin
						st_next.from_ram = 1'b0;
						st_next.fetch_addr = test_dump_pkg::EEPROM_FIRST_ADDR;
						st_next.last_addr = test_dump_pkg::EEPROM_LAST_ADDR;
					end else if (ram_ok) begin
						st_next.from_ram = 1'b1;
						st_next.fetch_addr = test_dump_pkg::RAM_OEM_FIRST_ADDR;
						st_next.last_addr = test_dump_pkg::RAM_OEM_LAST_ADDR;
					end else begin
						st_next.from_ram = 1'b0;
						st_next.fetch_addr =
							test_dump_pkg::EEPROM_OEM_FIRST_ADDR;
						st_next.last_addr = test_dump_pkg::EEPROM_LAST_ADDR;
					end
				end
			end
			test_dump_pkg::MODE_SEND, test_dump_pkg::MODE_HOLD: begin
				if (test_exit_below) begin
					// abort mid-byte: sink released, queued bytes dropped
					st_next.mode = test_dump_pkg::MODE_IDLE;
					st_next.tx = test_dump_pkg::TX_IDLE;
					st_next.fetch_busy = 1'b0;
					st_next.sink_on = 1'b0;
					fifo_bus.flush = 1'b1;
					if (sel != test_dump_pkg::SEL_OFF) begin
						st_next.reload_req = 1'b1;
						st_next.reload_id = st_reg.slave_id;
						if (sel == test_dump_pkg::SEL_FULL) begin
							st_next.reload_last =
								test_dump_pkg::EEPROM_LAST_ADDR;
						end else begin
							st_next.reload_last =
								test_dump_pkg::RELOAD_SHORT_LAST_ADDR;
						end
					end
					// code 00 simply drops back with no reload
				end else begin
					// fetch one byte at a time, only when the fifo has room
					if (!st_reg.fetch_done && !st_reg.fetch_busy &&
						fifo_bus.wr_ready) begin
						st_next.fetch_busy = 1'b1;
					end
					if (st_reg.fetch_busy && mem_ack) begin
						fifo_bus.wr_valid = 1'b1;
						st_next.fetch_busy = 1'b0;
						if (st_reg.fetch_addr == st_reg.last_addr) begin
							st_next.fetch_done = 1'b1;
						end else begin
							st_next.fetch_addr =
								st_reg.fetch_addr + 7'h01;
						end
					end

					case (st_reg.tx)
						test_dump_pkg::TX_IDLE: begin
							if (fifo_bus.rd_valid) begin
								fifo_bus.rd_ready = 1'b1;
								// start bit ahead of the data byte
								st_next.shift =
									{1'b1, fifo_bus.rd_data};
								st_next.bit_cnt = 4'h0;
								st_next.second_half = 1'b0;
								st_next.sink_on = 1'b1;
								st_next.tx = test_dump_pkg::TX_BITS;
							end else if (st_reg.fetch_done &&
								!st_reg.fetch_busy) begin
								st_next.mode = test_dump_pkg::MODE_HOLD;
							end
						end
						test_dump_pkg::TX_BITS: begin
							if (tick) begin
								if (!st_reg.second_half) begin
									st_next.second_half = 1'b1;
									st_next.sink_on =
										!st_reg.shift[8];
								end else if (st_reg.bit_cnt ==
									test_dump_pkg::FRAME_BITS - 4'h1) begin
									st_next.tx = test_dump_pkg::TX_PAUSE;
									st_next.pause_cnt = 5'h00;
									st_next.sink_on = 1'b0;
								end else begin
									st_next.shift =
										{st_reg.shift[7:0], 1'b0};
									st_next.bit_cnt =
										st_reg.bit_cnt + 4'h1;
									st_next.second_half = 1'b0;
									st_next.sink_on =
										st_reg.shift[7];
								end
							end
						end
						test_dump_pkg::TX_PAUSE: begin
							if (tick) begin
								if (st_reg.pause_cnt ==
									test_dump_pkg::PAUSE_PERIODS - 5'h01) begin
									st_next.tx =
										test_dump_pkg::TX_IDLE;
								end else begin
									st_next.pause_cnt =
										st_reg.pause_cnt + 5'h01;
								end
							end
						end
						default: begin
							st_next.tx = test_dump_pkg::TX_IDLE;
							st_next.sink_on = 1'b0;
						end
					endcase
				end
			end
			default: begin
				st_next = STATE_RESET;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= STATE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// memory fetch port
	assign mem_req = st_reg.fetch_busy && sending;
	assign mem_from_ram = st_reg.from_ram;
	assign mem_addr = st_reg.fetch_addr;
	assign mem_slave_id = st_reg.slave_id;

	// the sink only ever pulls low; the tester reads its current
	assign alarm_pin_out = 1'b0;
	assign alarm_pin_oe = st_reg.sink_on;

	assign test_mode_active = sending;
	assign reload_req = st_reg.reload_req;
	assign reload_last_addr = st_reg.reload_last;
	assign reload_slave_id = st_reg.reload_id;

endmodule

// File: sim/test_mode_config_dump_sva.sv
// port assertions for the test-mode dump block
`timescale 1ns/10ps
module test_mode_config_dump_sva (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic test_entry_above,
	input wire logic test_exit_below,
	input wire logic [7:0] cfg_select_byte,
	input wire logic mem_req,
	input wire logic mem_ack,
	input wire logic [6:0] mem_addr,
	input wire logic alarm_pin_oe,
	input wire logic test_mode_active,
	input wire logic reload_req,
	input wire logic [6:0] reload_last_addr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	entry_taken_a: assert property (
		!test_mode_active && test_entry_above && !test_exit_below &&
		cfg_select_byte[6] |=> test_mode_active) else $error("no entry");
	entry_refused_a: assert property (
		!test_mode_active && !cfg_select_byte[6] |=> !test_mode_active)
		else $error("entry without select");
	exit_stop_a: assert property (
		test_mode_active && test_exit_below
		|=> !test_mode_active && !alarm_pin_oe && !mem_req)
		else $error("exit did not stop");
	reload_pulse_a: assert property (
		test_mode_active && test_exit_below && cfg_select_byte[7:6] != 2'h0
		|=> reload_req ##1 !reload_req) else $error("reload missing");
	no_reload_a: assert property (
		test_mode_active && test_exit_below && cfg_select_byte[7:6] == 2'h0
		|=> !reload_req) else $error("reload with code zero");
	reload_range_a: assert property (
		reload_req |-> reload_last_addr ==
		($past(cfg_select_byte[7:6]) == 2'h3 ? 7'h7F : 7'h21))
		else $error("reload range wrong");
	req_hold_a: assert property (
		mem_req && !mem_ack && !test_exit_below
		|=> mem_req && $stable(mem_addr)) else $error("request dropped");
	half_min_a: assert property (
		$rose(alarm_pin_oe) |-> alarm_pin_oe[*8] or ##[1:8] !test_mode_active)
		else $error("sink half too short");
	cover property ($rose(test_mode_active));
	cover property ($rose(reload_req));
	cover property (mem_req && mem_ack);
endmodule

// File: sim/dump_partners.sv
// far side: pin decoder of the tester and the config memory
`timescale 1ns/10ps
module pin_tester (
	input wire logic sys_clk,
	input wire logic alarm_pin,
	input wire logic [7:0] half_cycles,
	output logic [7:0] rx_byte,
	output logic rx_strobe,
	output logic rx_bad
);
	logic [8:0] d;
	logic a;
	initial begin
		rx_strobe = 1'b0;
		rx_bad = 1'b0;
		rx_byte = 8'h00;
	end
	// samples mid-half, so slight phase error is tolerated
	always begin
		do @(posedge sys_clk); while (alarm_pin !== 1'b0);
		repeat (half_cycles / 2) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			a = !alarm_pin; // sink on in first half means one
			repeat (half_cycles) @(posedge sys_clk);
			if (!alarm_pin == a) rx_bad <= 1'b1;
			d = {d[7:0], a};
			repeat (half_cycles) @(posedge sys_clk);
		end
		if (!d[8]) rx_bad <= 1'b1;
		rx_byte <= d[7:0];
		rx_strobe <= 1'b1;
		@(posedge sys_clk);
		rx_strobe <= 1'b0;
		repeat (16 * half_cycles) begin
			@(posedge sys_clk);
			if (!alarm_pin) rx_bad <= 1'b1; // pause stays off
		end
	end
endmodule
module mem_model (
	input wire logic sys_clk,
	input wire logic mem_req,
	input wire logic mem_from_ram,
	input wire logic [6:0] mem_addr,
	input wire logic [3:0] lat,
	output logic mem_ack,
	output logic [7:0] mem_data
);
	logic [3:0] cnt = 4'h0;
	initial mem_ack = 1'b0;
	initial mem_data = 8'h00;
	always @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		if (mem_req && !mem_ack && cnt >= lat) begin
			mem_ack <= 1'b1;
			mem_data <= {mem_from_ram, mem_addr} ^ 8'h5A;
			cnt <= 4'h0;
		end else begin
			cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
			// data is not held outside the ack cycle
			mem_data <= ~mem_data;
		end
	end
endmodule

// File: sim/test_mode_config_dump_test.sv
// testbench for the test-mode configuration dump
`timescale 1ns/10ps
module test_mode_config_dump_test;
	logic sys_clk = 1'b0, resetn = 1'b0, test_entry_above = 1'b0;
	logic test_exit_below = 1'b0, fast_bit_rate_select = 1'b0;
	logic slave_operation_enable = 1'b0, alarm_pin, rx_strobe, rx_bad;
	logic [7:0] cfg_id_byte = 8'h2D, cfg_select_byte = 8'h00;
	logic [7:0] cfg_source_byte = 8'h00, half = 8'h27, rx_byte, mem_data;
	logic [3:0] lat = 4'h0;
	logic mem_req, mem_from_ram, mem_ack, alarm_pin_out, alarm_pin_oe;
	logic test_mode_active, reload_req;
	logic [6:0] mem_addr, mem_slave_id, reload_last_addr, reload_slave_id;
	int failures = 0, compares = 0;
	always #10 sys_clk = ~sys_clk;
	// pin is pulled up while the sink is off
	assign alarm_pin = alarm_pin_oe ? alarm_pin_out : 1'b1;
	test_mode_config_dump dut (.sys_clk, .resetn, .test_entry_above,
		.test_exit_below, .cfg_id_byte, .cfg_select_byte, .cfg_source_byte,
		.fast_bit_rate_select, .slave_operation_enable, .mem_req,
		.mem_from_ram, .mem_addr, .mem_slave_id, .mem_ack, .mem_data,
		.alarm_pin_out, .alarm_pin_oe, .test_mode_active, .reload_req,
		.reload_last_addr, .reload_slave_id);
	pin_tester tester (.sys_clk, .alarm_pin, .half_cycles(half), .rx_byte,
		.rx_strobe, .rx_bad);
	mem_model mem (.sys_clk, .mem_req, .mem_from_ram, .mem_addr, .lat,
		.mem_ack, .mem_data);
	function automatic logic [7:0] expb(input logic [6:0] a, input logic r);
		return {r, a} ^ 8'h5A;
	endfunction
	task automatic check(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic get_byte(input string n, input logic [7:0] e);
		int i;
		i = 0;
		do @(posedge sys_clk); while (rx_strobe !== 1'b1 && i++ < 9000);
		#1;
		check(n, e, rx_byte);
		check("byte seen", 8'h00, {7'h00, i > 9000});
		check("manchester form", 8'h00, {7'h00, rx_bad});
	endtask
	task automatic enter(input logic [1:0] code, input logic s, f, en,
		input logic [3:0] l);
		@(posedge sys_clk);
		cfg_select_byte <= {code, 6'h00};
		cfg_source_byte <= {s, 7'h00};
		fast_bit_rate_select <= f;
		slave_operation_enable <= en;
		lat <= l;
		half <= f ? test_dump_pkg::FAST_PERIOD_CYCLES :
			test_dump_pkg::SLOW_PERIOD_CYCLES;
		test_entry_above <= 1'b1;
		test_exit_below <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic leave(input logic [1:0] code, input logic r);
		@(posedge sys_clk);
		cfg_select_byte <= {code, 6'h00};
		test_exit_below <= 1'b1;
		test_entry_above <= 1'b0;
		@(posedge sys_clk);
		#1;
		check("active", 8'h00, {7'h00, test_mode_active});
		check("sink", 8'h00, {7'h00, alarm_pin_oe});
		check("reload", {7'h00, r}, {7'h00, reload_req});
		// tester still watches the pause; a new start would look like a fault
		repeat (16 * half) @(posedge sys_clk);
	endtask
	task automatic t_refuse();
		enter(2'h2, 1'b0, 1'b1, 1'b0, 4'h0);
		repeat (10) @(posedge sys_clk);
		#1;
		check("refused", 8'h00, {7'h00, test_mode_active});
		leave(2'h2, 1'b0);
		$display("test refuse done");
	endtask
	task automatic t_full();
		enter(2'h3, 1'b1, 1'b1, 1'b1, 4'h0);
		check("entered", 8'h01, {7'h00, test_mode_active});
		for (int i = 0; i < 3; i++)
			get_byte("full byte", expb(7'(i), 1'b0));
		check("fetch id", {1'b0, cfg_id_byte[6:0]}, {1'b0, mem_slave_id});
		leave(2'h3, 1'b1);
		check("reload end", 8'h7F, {1'b0, reload_last_addr});
		check("reload id", {1'b0, cfg_id_byte[6:0]}, {1'b0, reload_slave_id});
		$display("test full done");
	endtask
	task automatic t_ram();
		enter(2'h1, 1'b1, 1'b1, 1'b1, 4'h6);
		for (int i = 0; i < 9; i++)
			get_byte("ram byte", expb(7'h3B + 7'(i), 1'b1));
		repeat (50) @(posedge sys_clk);
		#1;
		check("req after range", 8'h00, {7'h00, mem_req});
		leave(2'h2, 1'b1);
		check("short reload", 8'h21, {1'b0, reload_last_addr});
		$display("test ram done");
	endtask
	task automatic t_slow();
		// ram source without slave mode falls back to eeprom
		enter(2'h1, 1'b1, 1'b0, 1'b0, 4'h0);
		get_byte("slow byte", expb(7'h1B, 1'b0));
		leave(2'h0, 1'b0);
		$display("test slow done");
	endtask
	task automatic t_abort();
		int i;
		enter(2'h3, 1'b0, 1'b1, 1'b1, 4'h0);
		i = 0;
		while (alarm_pin_oe !== 1'b1 && i++ < 200) begin
			@(posedge sys_clk);
			#1;
		end
		// start bit: sink on for exactly one fast period
		i = 0;
		while (alarm_pin_oe === 1'b1 && i < 200) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		check("start half", test_dump_pkg::FAST_PERIOD_CYCLES,
			8'(i));
		repeat (45) @(posedge sys_clk);
		leave(2'h1, 1'b1);
		check("req after abort", 8'h00, {7'h00, mem_req});
		$display("test abort done");
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		t_refuse();
		t_full();
		t_ram();
		t_slow();
		t_abort();
		report_and_stop();
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end
endmodule
bind test_mode_config_dump test_mode_config_dump_sva checker_inst (
	.sys_clk, .resetn, .test_entry_above, .test_exit_below,
	.cfg_select_byte, .mem_req, .mem_ack, .mem_addr, .alarm_pin_oe,
	.test_mode_active, .reload_req, .reload_last_addr);
